// file: dcsr_pkg.sv
// dcsr_pkg: register map, field positions and carriers for the disk controller status/error bank
// assumes a 32-bit apb slave with word-aligned registers
package dcsr_pkg;

    // register byte offsets
    localparam logic [7:0] DCSR_OFF_CONDITION = 8'h00;
    localparam logic [7:0] DCSR_OFF_FAULT     = 8'h04;
    localparam logic [7:0] DCSR_OFF_DIAG      = 8'h08;
    localparam logic [7:0] DCSR_OFF_IRQ_STAT  = 8'h0C;
    localparam logic [7:0] DCSR_OFF_IRQ_MASK  = 8'h10;
    localparam logic [7:0] DCSR_OFF_CTRL      = 8'h14;

    // controller_condition bit positions
    localparam int DCSR_CC_BUSY    = 7;
    localparam int DCSR_CC_ACCEPT  = 6;
    localparam int DCSR_CC_WFAULT  = 5;
    localparam int DCSR_CC_SETTLED = 4;
    localparam int DCSR_CC_XFER    = 3;
    localparam int DCSR_CC_CORRECTED_FLAG    = 2;
    localparam int DCSR_CC_INDEX   = 1;
    localparam int DCSR_CC_ERROR   = 0;

    // command_fault_cause bit positions
    localparam int DCSR_FC_BADBLK  = 7;
    localparam int DCSR_FC_UNCORR  = 6;
    localparam int DCSR_FC_IDMISS  = 4;
    localparam int DCSR_FC_ABORT   = 2;
    localparam int DCSR_FC_HOMEMIS = 1;

    // implemented bits of the fault register; 5, 3, 0 stay zero
    localparam logic [7:0] DCSR_FC_USED_MASK = 8'hD6;

    // interrupt status bit positions
    localparam int DCSR_IRQ_CMD_DONE  = 0;
    localparam int DCSR_IRQ_CMD_ERROR = 1;
    localparam int DCSR_IRQ_INDEX     = 2;
    localparam int DCSR_IRQ_CORRECTED_FLAG      = 3;
    localparam int DCSR_IRQ_W         = 4;

    // ctrl bit positions (write-one pulses)
    localparam int DCSR_CTRL_CLR_CORRECTED_FLAG  = 0;
    localparam int DCSR_CTRL_CLR_INDEX = 1;

    // reset values
    localparam logic [7:0]          DCSR_RST_BYTE = 8'h00;
    localparam logic [DCSR_IRQ_W-1:0] DCSR_RST_IRQ = 4'h0;
    localparam logic [31:0]         DCSR_RD_ZERO  = 32'h0000_0000;

    // live drive levels from the controller core
    typedef struct packed {
        logic busy;
        logic accepting;
        logic write_fault;
        logic settled;
        logic xfer_req;
    } dcsr_drive_t;

    // command completion report, valid on cmd_done
    typedef struct packed {
        logic cmd_done;
        logic corrected;
        logic bad_block;
        logic uncorrectable;
        logic id_missing;
        logic aborted;
        logic home_missing;
    } dcsr_result_t;

endpackage

// file: dcsr_regs.sv
// dcsr_regs: controller condition and command fault registers with apb access and interrupt
// assumes the controller core runs on i_mclk; the index pin is asynchronous and synchronised here
`timescale 1ns/1ps
module dcsr_regs
    import dcsr_pkg::*;
(
    input  wire logic         i_mclk,
    input  wire logic         i_srst,
    // apb slave
    input  wire logic         i_psel,
    input  wire logic         i_penable,
    input  wire logic         i_pwrite,
    input  wire logic [7:0]   i_paddr,
    input  wire logic [31:0]  i_pwdata,
    input  wire logic [3:0]   i_pstrb,
    output logic      [31:0]  o_prdata,
    output logic              o_pready,
    output logic              o_pslverr,
    // controller core, same clock
    input  wire dcsr_drive_t  i_drive,
    input  wire dcsr_result_t i_result,
    // index sensor pin, asynchronous
    input  wire logic         i_index_pin,
    // host-side status outputs
    output logic      [15:0]  o_diag_word,
    output logic              o_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // register map: one aligned 32-bit word each, unused upper bits read zero
    //
    //   0x00 condition   read-only; live drive levels plus three kept flags
    //   0x04 fault       read-only; causes of the last finished command
    //   0x08 diag        read-only; condition byte above fault byte
    //   0x0C irq status  write one to clear; events set it again at once
    //   0x10 irq mask    read/write; same layout as irq status
    //   0x14 ctrl        write-one pulses; reads zero, keeps nothing
    //   elsewhere        bus error; reads zero, writes dropped
    //
    // condition bits
    //   7 busy           live; controller still working on a command
    //   6 accepting      live; drive can take a new command
    //   5 write fault    live; write fault seen by the drive
    //   4 settled        live; heads sit over a track
    //   3 transfer req   live; drive ready to move data
    //   2 corrected      kept; a completion needed correction
    //   1 index          kept; index edge seen on the pin
    //   0 error          last completion reported some cause
    //
    // fault bits, rewritten as a whole by every completion
    //   7 bad block      block carries a bad mark
    //   6 uncorrectable  data error beyond correction
    //   4 id missing     no id field for the wanted sector
    //   2 aborted        command refused or drive status error
    //   1 home missing   recalibrate did not find the home track
    //   5, 3, 0          unused; always zero, writes cannot reach them
    //
    // irq status bits
    //   0 done           every completion
    //   1 done faulty    completion with any fault cause
    //   2 index          synchronised index edge
    //   3 corrected      completion that needed correction
    //
    // ctrl bits
    //   0 clear corrected flag
    //   1 clear index flag
    //   an event in the clearing cycle wins and keeps its flag set
    //
    // timing seen by software
    //   read data is captured at the setup edge and held to the next read
    //   a completion shows in reads set up one cycle later
    //   the diag port lags the live bits by one cycle
    //   a pin index edge reaches its flag three edges later
    //
    // limitations
    //   only the last completion's causes are kept; earlier ones are lost
    //   writes to the read-only words are dropped without a bus error
    //   byte lanes other than lane 0 carry nothing in this bank

    ////////////////////////////////////////////////////////////////////////////
    // index pin synchroniser and edge detect

    logic idx_s1_r;
    logic idx_s2_r;
    logic idx_s3_r;
    logic index_rise;

    // plain two-stage sync, third stage only for the edge;
    // only stage two reads stage one, so a metastable first flop never fans out
    // reset level matches the idle pin, so no false edge follows reset
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            idx_s1_r <= 1'b0;
            idx_s2_r <= 1'b0;
            idx_s3_r <= 1'b0;
        end else begin
            idx_s1_r <= i_index_pin;
            idx_s2_r <= idx_s1_r;
            idx_s3_r <= idx_s2_r;
        end
    end

    // one-cycle pulse on the synchronised rising edge
    assign index_rise = idx_s2_r & ~idx_s3_r;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    logic        wr_acc;
    logic        rd_setup;
    logic        ctrl_wr;
    logic        stat_wr;
    logic        mask_wr;
    logic        addr_ok;
    logic [31:0] wdata_m;

    // zero-wait slave: every access completes in its first access cycle,
    // so a write lands at the first access edge and never waits on the core
    assign o_pready = 1'b1;
    assign wr_acc   = i_psel & i_penable & i_pwrite;
    // read data is captured one edge early, in the setup phase
    assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
    assign addr_ok  = (i_paddr == DCSR_OFF_CONDITION) || (i_paddr == DCSR_OFF_FAULT)
                   || (i_paddr == DCSR_OFF_DIAG)      || (i_paddr == DCSR_OFF_IRQ_STAT)
                   || (i_paddr == DCSR_OFF_IRQ_MASK)  || (i_paddr == DCSR_OFF_CTRL);
    // unmapped words answer with an error but change nothing
    assign o_pslverr = i_psel & i_penable & ~addr_ok;

    // write strobes of the three writable words
    assign ctrl_wr  = wr_acc && (i_paddr == DCSR_OFF_CTRL);
    assign stat_wr  = wr_acc && (i_paddr == DCSR_OFF_IRQ_STAT);
    assign mask_wr  = wr_acc && (i_paddr == DCSR_OFF_IRQ_MASK);

    // byte-lane masked write data; only lane 0 matters in this bank
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wdata_m[i*8 +: 8] = i_pstrb[i] ? i_pwdata[i*8 +: 8] : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // condition and fault state
    // live levels pass straight through; only the flags below are stored

    logic       corrected_flag_r;
    logic       corrected_flag_nxt;
    logic       index_r;
    logic       index_nxt;
    logic       err_r;
    logic       err_nxt;
    logic [7:0] fault_r;
    logic [7:0] fault_nxt;
    logic       clr_corrected_flag;
    logic       clr_index;
    logic       new_fault;
    logic [7:0] fault_in;

    // ctrl is a pulse word; nothing stays behind for a later strobe to replay
    assign clr_corrected_flag  = ctrl_wr && wdata_m[DCSR_CTRL_CLR_CORRECTED_FLAG];
    assign clr_index = ctrl_wr && wdata_m[DCSR_CTRL_CLR_INDEX];

    // gather the causes of the finished command
    always_comb begin
        fault_in = DCSR_RST_BYTE;
        fault_in[DCSR_FC_BADBLK]  = i_result.bad_block;
        fault_in[DCSR_FC_UNCORR]  = i_result.uncorrectable;
        fault_in[DCSR_FC_IDMISS]  = i_result.id_missing;
        fault_in[DCSR_FC_ABORT]   = i_result.aborted;
        fault_in[DCSR_FC_HOMEMIS] = i_result.home_missing;
    end

    assign new_fault = |fault_in;

    // each completion replaces the fault byte; corrected_flag/index are sticky until cleared
    // a clear and a set in one cycle leave the flag set, so no event is lost
    always_comb begin
        fault_nxt = fault_r;
        err_nxt   = err_r;
        corrected_flag_nxt  = corrected_flag_r;
        index_nxt = index_r;
        if (i_result.cmd_done) begin
            fault_nxt = fault_in & DCSR_FC_USED_MASK;
            err_nxt   = new_fault;
        end
        if (clr_corrected_flag) begin
            corrected_flag_nxt = 1'b0;
        end
        if (i_result.cmd_done && i_result.corrected) begin
            corrected_flag_nxt = 1'b1;
        end
        if (clr_index) begin
            index_nxt = 1'b0;
        end
        if (index_rise) begin
            index_nxt = 1'b1;
        end
    end

    // plain register stage for the kept flags and the fault byte
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            fault_r <= DCSR_RST_BYTE;
            err_r   <= 1'b0;
            corrected_flag_r  <= 1'b0;
            index_r <= 1'b0;
        end else begin
            fault_r <= fault_nxt;
            err_r   <= err_nxt;
            corrected_flag_r  <= corrected_flag_nxt;
            index_r <= index_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // condition byte assembly and diagnostic word

    logic [7:0]  cond_byte;
    logic [15:0] diag_r;
    logic [15:0] diag_nxt;

    always_comb begin
        cond_byte = DCSR_RST_BYTE;
        cond_byte[DCSR_CC_BUSY]    = i_drive.busy;
        cond_byte[DCSR_CC_ACCEPT]  = i_drive.accepting;
        cond_byte[DCSR_CC_WFAULT]  = i_drive.write_fault;
        cond_byte[DCSR_CC_SETTLED] = i_drive.settled;
        cond_byte[DCSR_CC_XFER]    = i_drive.xfer_req;
        cond_byte[DCSR_CC_CORRECTED_FLAG]    = corrected_flag_r;
        cond_byte[DCSR_CC_INDEX]   = index_r;
        cond_byte[DCSR_CC_ERROR]   = err_r;
    end

    assign diag_nxt = {cond_byte, fault_r};

    // registered so the data output is glitch free; one cycle behind the live bits
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            diag_r <= {DCSR_RST_BYTE, DCSR_RST_BYTE};
        end else begin
            diag_r <= diag_nxt;
        end
    end

    assign o_diag_word = diag_r;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status and mask
    // level output; high while any unmasked status bit is set

    logic [DCSR_IRQ_W-1:0] irq_stat_r;
    logic [DCSR_IRQ_W-1:0] irq_stat_nxt;
    logic [DCSR_IRQ_W-1:0] irq_mask_r;
    logic [DCSR_IRQ_W-1:0] irq_mask_nxt;
    logic [DCSR_IRQ_W-1:0] irq_ev;
    logic                  irq_r;
    logic                  irq_nxt;

    // events that raise interrupt status bits
    always_comb begin
        irq_ev = DCSR_RST_IRQ;
        // every completion
        irq_ev[DCSR_IRQ_CMD_DONE]  = i_result.cmd_done;
        // completion with any cause
        irq_ev[DCSR_IRQ_CMD_ERROR] = i_result.cmd_done & new_fault;
        // synchronised pin edge
        irq_ev[DCSR_IRQ_INDEX]     = index_rise;
        // completion that needed correction
        irq_ev[DCSR_IRQ_CORRECTED_FLAG]      = i_result.cmd_done & i_result.corrected;
    end

    // write-one-to-clear; a same-cycle event keeps its bit set
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        irq_mask_nxt = irq_mask_r;
        if (stat_wr) begin
            irq_stat_nxt = irq_stat_r & ~wdata_m[DCSR_IRQ_W-1:0];
        end
        if (mask_wr) begin
            irq_mask_nxt = wdata_m[DCSR_IRQ_W-1:0];
        end
        // set after clear, so an event in the clearing cycle survives
        irq_stat_nxt = irq_stat_nxt | irq_ev;
    end

    // level follows the next state, so the pin and the status word agree
    assign irq_nxt = |(irq_stat_nxt & irq_mask_nxt);

    // mask resets to zero: no interrupt until software opts in
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            irq_stat_r <= DCSR_RST_IRQ;
            irq_mask_r <= DCSR_RST_IRQ;
            irq_r      <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            irq_r      <= irq_nxt;
        end
    end

    assign o_irq = irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // read data; condition and fault are read-only, writes to them are dropped
    // an unmapped word reads zero and raises pslverr in its access phase

    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    always_comb begin
        rdata_nxt = rdata_r;
        if (rd_setup) begin
            unique case (i_paddr)
                // live condition byte, kept flags included
                DCSR_OFF_CONDITION: rdata_nxt = {24'h00_0000, cond_byte};
                DCSR_OFF_FAULT:     rdata_nxt = {24'h00_0000, fault_r & DCSR_FC_USED_MASK};
                // live pair, one cycle ahead of the diag port
                DCSR_OFF_DIAG:      rdata_nxt = {16'h0000, diag_nxt};
                DCSR_OFF_IRQ_STAT:  rdata_nxt = {28'h000_0000, irq_stat_r};
                DCSR_OFF_IRQ_MASK:  rdata_nxt = {28'h000_0000, irq_mask_r};
                // ctrl and unmapped words read zero
                default:            rdata_nxt = DCSR_RD_ZERO;
            endcase
        end
    end

    // captured in setup so prdata comes from a flop during access
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            rdata_r <= DCSR_RD_ZERO;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign o_prdata = rdata_r;

endmodule // dcsr_regs

// file: dcsr_regs_asserts.sv
// checker: port relations of the status/error bank
// assumes one clock i_mclk and sync reset i_srst
`timescale 1ns/1ps
module dcsr_regs_asserts
    import dcsr_pkg::*;
(
    input wire logic         i_mclk,
    input wire logic         i_srst,
    input wire logic         i_psel,
    input wire logic         i_penable,
    input wire logic         i_pwrite,
    input wire logic [7:0]   i_paddr,
    input wire logic [31:0]  i_pwdata,
    input wire logic [3:0]   i_pstrb,
    input wire logic [31:0]  o_prdata,
    input wire logic         o_pready,
    input wire logic         o_pslverr,
    input wire dcsr_drive_t  i_drive,
    input wire dcsr_result_t i_result,
    input wire logic         i_index_pin,
    input wire logic [15:0]  o_diag_word,
    input wire logic         o_irq
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    // any cause at completion, for the error bit
    wire logic any_fault = |{i_result.bad_block, i_result.uncorrectable,
                             i_result.id_missing, i_result.aborted, i_result.home_missing};
    ////////////////////////////////////////////////////////////////////////////
    // live levels land in the diag word one cycle late; results two
    busy_mirror_a: assert property (!$past(i_srst) |-> o_diag_word[15] == $past(i_drive.busy))
        else $error("busy bit wrong");
    accept_mirror_a: assert property (!$past(i_srst) |-> o_diag_word[14] == $past(i_drive.accepting))
        else $error("accept bit wrong");
    wfault_mirror_a: assert property (!$past(i_srst) |-> o_diag_word[13] == $past(i_drive.write_fault))
        else $error("write fault bit wrong");
    corrected_flag_set_a: assert property (i_result.cmd_done && i_result.corrected |-> ##2 o_diag_word[10])
        else $error("corrected bit not set");
    index_set_a: assert property ($rose(i_index_pin) |-> ##[3:5] o_diag_word[9])
        else $error("index bit not set");
    error_bit_a: assert property (i_result.cmd_done |-> ##2 o_diag_word[8] == $past(any_fault, 2))
        else $error("error bit wrong");
    uncorr_bit_a: assert property (i_result.cmd_done |-> ##2 o_diag_word[6] == $past(i_result.uncorrectable, 2))
        else $error("uncorrectable bit wrong");
    home_bit_a: assert property (i_result.cmd_done |-> ##2 o_diag_word[1] == $past(i_result.home_missing, 2))
        else $error("track zero bit wrong");
    unused_zero_a: assert property ((o_diag_word & 16'h0029) == 16'h0000)
        else $error("unused fault bit set");
    cover property (i_result.cmd_done && i_result.aborted);
    cover property (o_irq);
    cover property (o_pslverr);
endmodule // dcsr_regs_asserts

bind dcsr_regs dcsr_regs_asserts chk (.i_mclk(i_mclk), .i_srst(i_srst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_drive(i_drive), .i_result(i_result), .i_index_pin(i_index_pin),
    .o_diag_word(o_diag_word), .o_irq(o_irq));

// file: dcsr_host.sv
// host model: apb master reaching the bank registers
// assumes xfer is called from one process at a time
`timescale 1ns/1ps
module dcsr_host (
    input  wire logic        i_mclk,
    input  wire logic        i_pready,
    input  wire logic        i_pslverr,
    input  wire logic [31:0] i_prdata,
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic [7:0]       o_paddr,
    output logic [31:0]      o_pwdata,
    output logic [3:0]       o_pstrb
);
    bit hung = 0;
    // idle bus from time zero
    initial begin
        {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata} = '0;
        o_pstrb = 4'hF;
    end
    ////////////////////////////////////////////////////////////////////////////
    // request held until pready seen at an edge; bounded so a dead slave ends
    // whole diag word taken in one read
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge i_mclk);
        o_psel   <= 1'b1;
        o_pwrite <= w;
        o_paddr  <= a;
        o_pwdata <= d;
        o_pstrb  <= s;
        @(posedge i_mclk);
        o_penable <= 1'b1;
        do begin
            @(posedge i_mclk);
            n++;
        end while (i_pready !== 1'b1 && n < 50);
        hung = (i_pready !== 1'b1);
        q = i_prdata;
        e = i_pslverr;
        o_psel    <= 1'b0;
        o_penable <= 1'b0;
    endtask
endmodule // dcsr_host

// file: tb_top.sv
// bench: drives the bank, mirrors it in a behavioural model
// assumes zero-wait apb and live drive levels per the hand-over
`timescale 1ns/1ps
module tb_top
    import dcsr_pkg::*;
;
    logic         i_mclk = 0, i_srst = 1, pin = 0, pready, pslverr, irq;
    logic         psel, pen, pwr, corrected_flag_s = 0, idx_s = 0, err_s = 0;
    logic [7:0]   paddr, fault_m = '0;
    logic [31:0]  pwdata, prdata;
    logic [3:0]   pstrb, stat_m = '0, strb = 4'hF;
    logic [15:0]  diag;
    logic [4:0]   c;
    dcsr_drive_t  drv = '0;
    dcsr_result_t res = '0;
    int           n_errors = 0, check_count = 0;
    logic [7:0]   offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};

    dcsr_host host (.i_mclk(i_mclk), .i_pready(pready), .i_pslverr(pslverr), .i_prdata(prdata),
        .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata),
        .o_pstrb(pstrb));
    dcsr_regs dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_drive(drv), .i_result(res),
        .i_index_pin(pin), .o_diag_word(diag), .o_irq(irq));

    // 50 mhz clock
    initial forever #10 i_mclk = ~i_mclk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) begin
            n_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    // a hung access counts and closes the run
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        host.xfer(w, a, d, strb, q, e);
        if (host.hung) begin
            n_errors++;
            conclude();
        end else begin
            if (!w) chk(q, x);
            chk({31'h0, e}, {31'h0, a > DCSR_OFF_CTRL});
        end
    endtask
    function automatic logic [7:0] cond();
        return {drv, corrected_flag_s, idx_s, err_s};
    endfunction
    // one completion report and its effect on the model
    task automatic cmd(input logic cr, input logic [4:0] f);
        @(posedge i_mclk);
        res <= {1'b1, cr, f};
        @(posedge i_mclk);
        res <= '0;
        fault_m = {f[4:3], 1'b0, f[2], 1'b0, f[1:0], 1'b0};
        err_s = |f;
        corrected_flag_s |= cr;
        stat_m |= {cr, 1'b0, |f, 1'b1};
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge i_mclk);
        n_errors++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h5b5c));
        repeat (6) @(posedge i_mclk);
        i_srst <= 1'b0;
        foreach (offs[i]) acc(1'b0, offs[i], '0, '0);
        $display("reset test done");
        repeat (8) begin
            @(posedge i_mclk);
            drv <= 5'($urandom);
            @(posedge i_mclk);
            acc(1'b0, DCSR_OFF_CONDITION, '0, {24'h0, cond()});
        end
        $display("drive test done");
        for (int i = 0; i < 7; i++) begin
            c = (i < 5) ? 5'(1 << i) : 5'($urandom);
            cmd(i == 6, c);
            acc(1'b1, DCSR_OFF_FAULT, 32'h0000_00FF, '0);
            acc(1'b0, DCSR_OFF_FAULT, '0, {24'h0, fault_m});
            acc(1'b0, DCSR_OFF_CONDITION, '0, {24'h0, cond()});
            acc(1'b0, DCSR_OFF_DIAG, '0, {16'h0, cond(), fault_m});
            #1 chk({16'h0, diag}, {16'h0, cond(), fault_m});
        end
        $display("result test done");
        @(posedge i_mclk);
        pin <= 1'b1;
        repeat (5) @(posedge i_mclk);
        pin <= 1'b0;
        idx_s = 1'b1;
        stat_m[DCSR_IRQ_INDEX] = 1'b1;
        acc(1'b0, DCSR_OFF_CONDITION, '0, {24'h0, cond()});
        // lane 0 masked off: the clear pulses must not reach the flags
        strb = 4'hE;
        acc(1'b1, DCSR_OFF_CTRL, 32'h0000_0003, '0);
        acc(1'b0, DCSR_OFF_CONDITION, '0, {24'h0, cond()});
        strb = 4'hF;
        acc(1'b1, DCSR_OFF_CTRL, 32'h0000_0003, '0);
        {corrected_flag_s, idx_s} = 2'h0;
        acc(1'b0, DCSR_OFF_CONDITION, '0, {24'h0, cond()});
        $display("sticky test done");
        acc(1'b0, DCSR_OFF_IRQ_STAT, '0, {28'h0, stat_m});
        #1 chk({31'h0, irq}, '0);
        acc(1'b1, DCSR_OFF_IRQ_MASK, 32'h0000_000F, '0);
        repeat (2) @(posedge i_mclk);
        #1 chk({31'h0, irq}, 32'h0000_0001);
        acc(1'b1, DCSR_OFF_IRQ_STAT, 32'h0000_000F, '0);
        repeat (2) @(posedge i_mclk);
        #1 chk({31'h0, irq}, '0);
        acc(1'b0, DCSR_OFF_IRQ_STAT, '0, '0);
        $display("irq test done");
        conclude();
    end
endmodule // tb_top
